/* verilog/plc_pkg.sv */
package plc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int BANNER_MS    = 2000;
  localparam int BANNER_CYC   = (CLK_HZ / 1000) * BANNER_MS;
  localparam int BLINK_MS     = 250;
  localparam int BLINK_CYC    = (CLK_HZ / 1000) * BLINK_MS;
  localparam int SETTLE_CYC   = 3;

  // ----------------------------------------------------------------
  // limits
  // ----------------------------------------------------------------
  localparam logic [15:0] VA_LIMIT_SMALL   = 16'h0096;
  localparam logic [15:0] VA_LIMIT_LARGE   = 16'h00DC;
  localparam logic [15:0] VOLTAGE_CEILING_CAUSE_MV    = 16'h15E0;
  localparam logic [23:0] DEV_PCT          = 24'h00000A;
  localparam logic [23:0] PCT_FULL         = 24'h000064;
  localparam logic [15:0] CUR_DEF_SMALL_MA = 16'h0BB8;
  localparam logic [15:0] CUR_DEF_LARGE_MA = 16'h1770;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_EN   = 8'h14;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_STOP     = 1;
  localparam int          CFG_W         = 20;
  localparam int          CFG_FREQ      = 16;
  localparam int          CFG_LOWER     = 17;
  localparam int          CFG_OFFSET    = 18;
  localparam int          CFG_TIMER     = 19;
  localparam logic [19:0] CFG_RST       = {4'h0, CUR_DEF_SMALL_MA};
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_PROT      = 0;
  localparam int          IRQ_START     = 1;
  localparam int          IRQ_END       = 2;
  localparam int          IRQ_RESTORE   = 3;
  localparam logic [3:0]  IRQ_EN_RST    = 4'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // synchronised pin inputs
  // ----------------------------------------------------------------
  localparam int         SYNC_W    = 10;
  localparam int         SI_TEMP   = 0;
  localparam int         SI_SHIFT  = 1;
  localparam int         SI_PSTART = 2;
  localparam int         SI_PSTOP  = 3;
  localparam int         SI_RSTART = 4;
  localparam int         SI_RSTOP  = 5;
  localparam int         SI_SSTART = 6;
  localparam int         SI_SSTOP  = 7;
  localparam int         SI_ENA    = 8;
  localparam int         SI_VAR    = 9;
  localparam logic [9:0] SYNC_RST  = 10'h1C0;

  localparam int TRIP_W = 5;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_READY = 2'b01,
    ST_TEST  = 2'b10,
    ST_PROT  = 2'b11
  } plc_state_type;

  typedef enum logic [2:0] {
    CAUSE_NONE      = 3'b000,
    CAUSE_OVERHEAT  = 3'b001,
    CAUSE_OVERLOAD  = 3'b010,
    CAUSE_VOLTAGE   = 3'b011,
    CAUSE_EXT_IFACE = 3'b100,
    CAUSE_CURRENT   = 3'b101
  } plc_cause_type;

endpackage : plc_pkg

/* verilog/plc_cause_if.sv */
`timescale 1ns/1ps
interface plc_cause_if;
  import plc_pkg::*;
  logic [TRIP_W-1:0] trip;
  logic              clear_req;
  logic              temp_hot;
  logic              prot;
  plc_cause_type     cause;
  modport ctrl  (output trip, clear_req, temp_hot, input prot, cause);
  modport latch (input trip, clear_req, temp_hot, output prot, cause);
endinterface : plc_cause_if

/* verilog/plc_sync.sv */
`timescale 1ns/1ps
module plc_sync import plc_pkg::*; #(
  parameter int          W       = SYNC_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } plc_sync_state_type;

  plc_sync_state_type r;
  plc_sync_state_type r_nxt;

  // s1 feeds s2 only; nothing else may look at the metastable stage
  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = din;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{s1: RST_VAL, s2: RST_VAL};
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  assign dout = r.s2;

endmodule : plc_sync

/* verilog/plc_cause_latch.sv */
`timescale 1ns/1ps
module plc_cause_latch import plc_pkg::*; (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  plc_cause_if.latch cif
);

  typedef struct packed {
    logic          prot;
    plc_cause_type cause;
  } plc_latch_state_type;

  plc_latch_state_type r;
  plc_latch_state_type r_nxt;

  always_comb begin
    r_nxt = r;
    if (!r.prot) begin
      // lowest index wins when several causes arrive in the same cycle
      for (int i = TRIP_W - 1; i >= 0; i--) begin
        if (cif.trip[i]) begin
          r_nxt.prot  = 1'b1;
          r_nxt.cause = plc_cause_type'(3'(i + 1));
        end
      end
    end else if (cif.clear_req && !cif.temp_hot && (cif.trip == '0)) begin
      // a hot sensor or a fresh trip keeps the latch: trip beats clear
      r_nxt.prot  = 1'b0;
      r_nxt.cause = CAUSE_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{prot: 1'b0, cause: CAUSE_NONE};
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  assign cif.prot  = r.prot;
  assign cif.cause = r.cause;

endmodule : plc_cause_latch

/* verilog/plc_top.sv */
// Overview of operation
// - overtemperature trips protection, overheat code blinks
// - overheat clears only by stop when cool
// - power above 150/220 VA trips overload
// - overload check runs even for accepted settings
// - overload stays latched until stop
// - over 5.6 V, not failed, trips limit
// - voltage limit stays latched until stop
// - enable level change trips; stop clears it
// - current off by over 10 percent trips
// - shift held through banner restores defaults
// - restore also erases stored test programs
// - defaults: 3.0/6.0 A, 50 Hz, options off
// - remote option starts/stops; panel stops, but starts only with enable high
// - connector starts, stops and shows status
// - protection lights indicator and halts test
// - protection output active while protection holds
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module plc_top import plc_pkg::*; #(
  parameter int BANNER_CYCLES = BANNER_CYC,
  parameter int BLINK_CYCLES  = BLINK_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              temp_hot_pin,
  input  wire logic              shift_key,
  input  wire logic              panel_start,
  input  wire logic              panel_stop,
  input  wire logic              remote_start,
  input  wire logic              remote_stop,
  input  wire logic              sio_start_n,
  input  wire logic              sio_stop_n,
  input  wire logic              sio_enable_n,
  input  wire logic              large_variant,
  input  wire logic [15:0]       meas_va,
  input  wire logic [15:0]       meas_volt_mv,
  input  wire logic [15:0]       meas_curr_ma,
  input  wire logic              judged_fail,
  output logic                   test_on,
  output logic                   ready,
  output logic                   prot_led,
  output logic [2:0]             cause_code,
  output logic                   cause_blink,
  output logic                   sio_drive_level,
  output logic                   sio_test_oe,
  output logic                   sio_ready_oe,
  output logic                   sio_prot_oe,
  output logic [15:0]            set_current_ma,
  output logic                   freq_60hz,
  output logic                   lower_on,
  output logic                   offset_on,
  output logic                   timer_on,
  output logic                   prog_erase,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    plc_state_type     st;
    logic [26:0]       boot_cnt;
    logic              shift_ok;
    logic              variant;
    logic [1:0]        settle;
    logic              en_prev;
    logic [2:0]        start_prev;
    logic [24:0]       blink_cnt;
    logic              blink;
    logic              prot_prev;
    logic [CFG_W-1:0]  cfg;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_en;
    logic              erase;
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } plc_top_state_type;

  plc_top_state_type r;
  plc_top_state_type r_nxt;

  logic [SYNC_W-1:0] sy;
  plc_cause_if       cif ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    if (a == ADDR_CTRL) begin
      return 1'b1;
    end else if (a == ADDR_CONFIG || a == ADDR_STATUS) begin
      return 1'b1;
    end else if (a == ADDR_IRQ_STAT || a == ADDR_IRQ_CLR || a == ADDR_IRQ_EN) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addr_known

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // pin synchronisers and cause latch
  // ----------------------------------------------------------------
  plc_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     ({large_variant, sio_enable_n, sio_stop_n, sio_start_n, remote_stop,
               remote_start, panel_stop, panel_start, shift_key, temp_hot_pin}),
    .dout    (sy)
  );

  plc_cause_latch u_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cif     (cif)
  );

  // ----------------------------------------------------------------
  // protection conditions
  // ----------------------------------------------------------------
  logic        testing;
  logic        ena_low;
  logic [2:0]  start_lv;
  logic [2:0]  start_rise;
  logic        stop_req;
  logic        start_req;
  logic [15:0] va_limit;
  logic [15:0] dev_ma;
  logic [23:0] dev_scaled;
  logic [23:0] dev_allowed;
  logic        do_write;
  logic        sw_start;
  logic        sw_stop;

  assign testing     = (r.st == ST_TEST);
  assign ena_low     = !sy[SI_ENA];
  // connector start counts only with enable low, the panel key only with it high
  assign start_lv    = {!sy[SI_SSTART] && ena_low, sy[SI_RSTART],
                        sy[SI_PSTART] && !ena_low};
  assign start_rise  = start_lv & ~r.start_prev;
  assign do_write    = r.aw_got && r.w_got && !r.bvalid && ce;
  assign sw_start    = do_write && (r.awaddr == ADDR_CTRL) && r.wstrb[0] &&
                       r.wdata[CTRL_START];
  assign sw_stop     = do_write && (r.awaddr == ADDR_CTRL) && r.wstrb[0] &&
                       r.wdata[CTRL_STOP];
  assign stop_req    = sy[SI_PSTOP] || sy[SI_RSTOP] || !sy[SI_SSTOP] ||
                       sw_stop;
  assign start_req   = (start_rise != 3'h0) || sw_start;
  assign va_limit    = r.variant ? VA_LIMIT_LARGE : VA_LIMIT_SMALL;
  assign dev_ma      = (meas_curr_ma > r.cfg[15:0]) ? (meas_curr_ma - r.cfg[15:0])
                                                    : (r.cfg[15:0] - meas_curr_ma);
  assign dev_scaled  = 24'(dev_ma) * PCT_FULL;
  assign dev_allowed = 24'(r.cfg[15:0]) * DEV_PCT;

  assign cif.temp_hot  = sy[SI_TEMP];
  assign cif.clear_req = stop_req;
  // overheat watches at all times; load checks only while a test drives
  assign cif.trip[0] = sy[SI_TEMP];
  assign cif.trip[1] = testing && (meas_va > va_limit);
  assign cif.trip[2] = testing && !judged_fail &&
                       (meas_volt_mv > VOLTAGE_CEILING_CAUSE_MV);
  assign cif.trip[3] = (r.settle == 2'(SETTLE_CYC)) &&
                       (sy[SI_ENA] != r.en_prev);
  assign cif.trip[4] = testing && !judged_fail &&
                       (dev_scaled > dev_allowed);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [31:0]      rd;
    ev    = '0;
    rd    = '0;
    r_nxt = r;
    r_nxt.erase      = 1'b0;
    r_nxt.start_prev = start_lv;
    r_nxt.en_prev    = sy[SI_ENA];
    r_nxt.prot_prev  = cif.prot;
    if (r.settle != 2'(SETTLE_CYC)) begin
      // wait for the synchroniser to carry the real pin level
      r_nxt.settle = r.settle + 2'h1;
    end

    // test sequencing
    case (r.st)
      ST_BOOT: begin
        r_nxt.shift_ok = r.shift_ok && (sy[SI_SHIFT] || r.settle != 2'(SETTLE_CYC));
        r_nxt.boot_cnt = r.boot_cnt + 27'h1;
        if (r.boot_cnt == 27'(BANNER_CYCLES - 1)) begin
          r_nxt.st      = ST_READY;
          r_nxt.variant = sy[SI_VAR];
          if (r.shift_ok && sy[SI_SHIFT]) begin
            r_nxt.cfg = {4'h0, sy[SI_VAR] ? CUR_DEF_LARGE_MA
                                         : CUR_DEF_SMALL_MA};
            r_nxt.erase     = 1'b1;
            ev[IRQ_RESTORE] = 1'b1;
          end
        end
      end
      ST_READY: begin
        if (cif.prot) begin
          r_nxt.st = ST_PROT;
        end else if (start_req) begin
          r_nxt.st      = ST_TEST;
          ev[IRQ_START] = 1'b1;
        end
      end
      ST_TEST: begin
        if (cif.prot) begin
          r_nxt.st    = ST_PROT;
          ev[IRQ_END] = 1'b1;
        end else if (stop_req) begin
          r_nxt.st    = ST_READY;
          ev[IRQ_END] = 1'b1;
        end
      end
      ST_PROT: begin
        // starts are dropped here; only the latch release leaves
        if (!cif.prot) begin
          r_nxt.st = ST_READY;
        end
      end
      default: begin
        r_nxt.st = ST_READY;
      end
    endcase
    if (cif.prot && r.st != ST_PROT && r.st != ST_BOOT) begin
      r_nxt.st = ST_PROT;
    end

    // cause code blinking
    if (cif.prot) begin
      if (r.blink_cnt == 25'(BLINK_CYCLES - 1)) begin
        r_nxt.blink_cnt = '0;
        r_nxt.blink     = !r.blink;
      end else begin
        r_nxt.blink_cnt = r.blink_cnt + 25'h1;
      end
    end else begin
      r_nxt.blink_cnt = '0;
      r_nxt.blink     = 1'b1;
    end
    ev[IRQ_PROT] = cif.prot && !r.prot_prev;

    // write channel
    if (s_axi_awvalid && s_axi_awready) begin
      r_nxt.aw_got = 1'b1;
      r_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_nxt.w_got = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got  = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = addr_known(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (r.awaddr == ADDR_CONFIG) begin
        r_nxt.cfg = CFG_W'(merge(32'(r.cfg), r.wdata, r.wstrb));
      end else if (r.awaddr == ADDR_IRQ_EN) begin
        r_nxt.irq_en = IRQ_W'(merge(32'(r.irq_en), r.wdata, r.wstrb));
      end else if (r.awaddr == ADDR_IRQ_CLR && r.wstrb[0]) begin
        r_nxt.irq_st = r.irq_st & ~r.wdata[IRQ_W-1:0];
      end
    end
    // a new event in the clearing cycle survives
    r_nxt.irq_st = r_nxt.irq_st | ev;
    if (r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end

    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      if (s_axi_araddr == ADDR_CONFIG) begin
        rd = 32'(r.cfg);
      end else if (s_axi_araddr == ADDR_STATUS) begin
        rd = {21'h0, r.variant, sy[SI_ENA], cif.prot, 1'b0, cif.cause, 2'h0, r.st};
      end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
        rd = 32'(r.irq_st);
      end else if (s_axi_araddr == ADDR_IRQ_EN) begin
        rd = 32'(r.irq_en);
      end else begin
        rd = 32'h0000_0000;
      end
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata  = rd;
      r_nxt.rresp  = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{st: ST_BOOT, boot_cnt: '0, shift_ok: 1'b1, variant: 1'b0, settle: '0,
             en_prev: 1'b1, start_prev: '0, blink_cnt: '0, blink: 1'b1,
             prot_prev: 1'b0, cfg: CFG_RST, irq_st: '0, irq_en: IRQ_EN_RST,
             erase: 1'b0, aw_got: 1'b0, awaddr: '0, w_got: 1'b0, wdata: '0,
             wstrb: '0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: '0,
             rresp: RESP_OKAY};
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready  = ce && !r.aw_got && !r.bvalid;
  assign s_axi_wready   = ce && !r.w_got && !r.bvalid;
  assign s_axi_bvalid   = r.bvalid;
  assign s_axi_bresp    = r.bresp;
  assign s_axi_arready  = ce && !r.rvalid;
  assign s_axi_rvalid   = r.rvalid;
  assign s_axi_rdata    = r.rdata;
  assign s_axi_rresp    = r.rresp;
  assign test_on        = (r.st == ST_TEST);
  assign ready          = (r.st == ST_READY);
  assign prot_led       = cif.prot;
  assign cause_code     = cif.cause;
  assign cause_blink    = cif.prot && r.blink;
  // open-drain outputs pull low whenever enabled
  assign sio_drive_level = 1'b0;
  assign sio_test_oe    = (r.st == ST_TEST);
  assign sio_ready_oe   = (r.st == ST_READY);
  assign sio_prot_oe    = cif.prot;
  assign set_current_ma = r.cfg[15:0];
  assign freq_60hz      = r.cfg[CFG_FREQ];
  assign lower_on       = r.cfg[CFG_LOWER];
  assign offset_on      = r.cfg[CFG_OFFSET];
  assign timer_on       = r.cfg[CFG_TIMER];
  assign prog_erase     = r.erase;
  assign irq            = |(r.irq_st & r.irq_en);

endmodule : plc_top

/* verification/plc_ext_ctrl.sv */
`timescale 1ns/1ps
module plc_ext_ctrl (
  input  wire logic aclk,
  input  wire logic go,
  input  wire logic halt,
  input  wire logic arm,
  output logic      sio_start_n,
  output logic      sio_stop_n,
  output logic      sio_enable_n
);
  // pulled-up lines: a released request reads high
  initial begin
    sio_start_n  = 1'b1;
    sio_stop_n   = 1'b1;
    sio_enable_n = 1'b1;
  end
  always @(posedge aclk) begin
    sio_start_n  <= !go;
    sio_stop_n   <= !halt;
    sio_enable_n <= !arm;
  end
endmodule : plc_ext_ctrl

/* verification/plc_top_monitor.sv */
`timescale 1ns/1ps
module plc_top_monitor import plc_pkg::*; (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        temp_hot_pin,
  input wire logic        panel_stop,
  input wire logic        remote_stop,
  input wire logic        sio_stop_n,
  input wire logic        sio_enable_n,
  input wire logic [15:0] meas_va,
  input wire logic [15:0] meas_volt_mv,
  input wire logic        judged_fail,
  input wire logic        test_on,
  input wire logic        ready,
  input wire logic        prot_led,
  input wire logic [2:0]  cause_code,
  input wire logic        sio_prot_oe
);
  logic [7:0] quiet_r;
  // stops pass a synchroniser, so a clear is legal only shortly after one
  always_ff @(posedge aclk) begin
    if (!aresetn || panel_stop || remote_stop || !sio_stop_n) begin
      quiet_r <= 8'h00;
    end else if (quiet_r != 8'hFF) begin
      quiet_r <= quiet_r + 8'h01;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_heat_trip: assert property ($rose(temp_hot_pin) |-> ##[1:6] prot_led)
    else $error("overheat missed");
  a_load_trip: assert property (test_on && meas_va > VA_LIMIT_SMALL |-> ##[1:3] prot_led)
    else $error("overload missed");
  a_volt_trip: assert property (test_on && !judged_fail && meas_volt_mv > VOLTAGE_CEILING_CAUSE_MV
    |-> ##[1:3] prot_led)
    else $error("voltage limit missed");
  a_enable_trip: assert property ($changed(sio_enable_n) |-> ##[1:6] prot_led)
    else $error("enable change missed");
  a_clear_by_stop: assert property ($fell(prot_led) |-> quiet_r < 8'h08)
    else $error("protection cleared without stop");
  a_halt_on_prot: assert property (prot_led ##1 prot_led |-> !test_on && !ready)
    else $error("test runs under protection");
  a_cause_held: assert property (prot_led && $past(prot_led) |-> $stable(cause_code))
    else $error("cause changed while latched");
  a_prot_pin: assert property (prot_led [*2] |-> sio_prot_oe)
    else $error("protection pin idle");
  c_trip: cover property ($rose(prot_led));
  c_clear: cover property ($fell(prot_led));
  c_load: cover property (test_on && meas_va > VA_LIMIT_SMALL);
endmodule : plc_top_monitor
bind plc_top plc_top_monitor u_plc_top_monitor (.*);

/* verification/test_protection_latch_controller.sv */
`timescale 1ns/1ps
module test_protection_latch_controller;
  import plc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, go = 1'b0, halt = 1'b0, arm = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, temp_hot_pin = 1'b0, shift_key = 1'b0;
  logic panel_start = 1'b0, panel_stop = 1'b0, remote_start = 1'b0, remote_stop = 1'b0;
  logic large_variant = 1'b0, judged_fail = 1'b0, erased;
  logic [15:0] meas_va = 16'h0, meas_volt_mv = 16'h0, meas_curr_ma = 16'h0BB8;
  logic [15:0] set_current_ma;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [2:0] cause_code;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sio_start_n, sio_stop_n, sio_enable_n, test_on, ready, prot_led, cause_blink;
  logic sio_drive_level, sio_test_oe, sio_ready_oe, sio_prot_oe, freq_60hz, lower_on;
  logic offset_on, timer_on, prog_erase, irq;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  plc_top #(.BANNER_CYCLES(20), .BLINK_CYCLES(4)) u_plc_top (.*);
  plc_ext_ctrl u_plc_ext_ctrl (.*);
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (prog_erase === 1'b1) erased = 1'b1;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // lets the edge's updates land before anything is looked at
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      #1;
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    chk(rr, RESP_OKAY);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      #1;
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    chk(rd, e);
    chk(rr, er);
  endtask : rdc
  task automatic trip(input logic [2:0] c);
    tick(6);
    chk(prot_led, 1'b1);
    chk(cause_code, c);
    chk(test_on, 1'b0);
  endtask : trip
  task automatic hstop;
    halt <= 1'b1;
    tick(3);
    halt <= 1'b0;
    tick(6);
  endtask : hstop
  task automatic t_boot;
    tick(30);
    chk(ready, 1'b1);
    rdc(ADDR_CONFIG, 32'h0BB8, RESP_OKAY);
    rdc(8'hFC, 32'h0, RESP_SLVERR);
    $display("boot done");
  endtask : t_boot
  task automatic t_load;
    wr(ADDR_IRQ_EN, 32'h1);
    panel_start <= 1'b1;
    tick(4);
    panel_start <= 1'b0;
    chk(test_on, 1'b1);
    chk({sio_test_oe, sio_ready_oe, sio_drive_level}, 3'h4);
    meas_va <= VA_LIMIT_SMALL;
    tick(4);
    chk(prot_led, 1'b0);
    meas_va <= 16'h0097;
    trip(CAUSE_OVERLOAD);
    chk(cause_blink, 1'b0);
    meas_va <= 16'h0000;
    chk(irq, 1'b1);
    chk(sio_prot_oe, 1'b1);
    remote_start <= 1'b1;
    tick(5);
    remote_start <= 1'b0;
    chk(test_on, 1'b0);
    chk(cause_blink, 1'b1);
    chk(prot_led, 1'b1);
    remote_stop <= 1'b1;
    tick(3);
    remote_stop <= 1'b0;
    tick(6);
    chk(ready, 1'b1);
    chk({sio_test_oe, sio_ready_oe}, 2'h1);
    wr(ADDR_IRQ_CLR, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    $display("overload done");
  endtask : t_load
  task automatic t_volt;
    wr(ADDR_CTRL, 32'h1);
    tick(3);
    chk(test_on, 1'b1);
    judged_fail <= 1'b1;
    meas_volt_mv <= 16'h15E1;
    tick(5);
    chk(prot_led, 1'b0);
    judged_fail <= 1'b0;
    trip(CAUSE_VOLTAGE);
    meas_volt_mv <= 16'h0000;
    temp_hot_pin <= 1'b1;
    tick(5);
    temp_hot_pin <= 1'b0;
    chk(cause_code, CAUSE_VOLTAGE);
    tick(4);
    hstop;
    chk(ready, 1'b1);
    $display("voltage done");
  endtask : t_volt
  task automatic t_curr;
    remote_start <= 1'b1;
    tick(4);
    remote_start <= 1'b0;
    chk(test_on, 1'b1);
    meas_curr_ma <= 16'h0CE4;
    tick(5);
    chk(prot_led, 1'b0);
    meas_curr_ma <= 16'h0CE5;
    trip(CAUSE_CURRENT);
    meas_curr_ma <= 16'h0BB8;
    panel_stop <= 1'b1;
    tick(3);
    panel_stop <= 1'b0;
    tick(6);
    chk(ready, 1'b1);
    $display("current done");
  endtask : t_curr
  task automatic t_ena_heat;
    arm <= 1'b1;
    trip(CAUSE_EXT_IFACE);
    hstop;
    go <= 1'b1;
    tick(5);
    go <= 1'b0;
    chk(test_on, 1'b1);
    hstop;
    arm <= 1'b0;
    trip(CAUSE_EXT_IFACE);
    hstop;
    temp_hot_pin <= 1'b1;
    trip(CAUSE_OVERHEAT);
    hstop;
    chk(prot_led, 1'b1);
    temp_hot_pin <= 1'b0;
    tick(4);
    hstop;
    chk(ready, 1'b1);
    $display("enable and heat done");
  endtask : t_ena_heat
  task automatic t_restore;
    erased = 1'b0;
    large_variant <= 1'b1;
    shift_key <= 1'b1;
    aresetn <= 1'b0;
    tick(8);
    aresetn <= 1'b1;
    tick(30);
    shift_key <= 1'b0;
    chk(erased, 1'b1);
    chk(set_current_ma, 16'h1770);
    chk({freq_60hz, lower_on, offset_on, timer_on}, 4'h0);
    $display("restore done");
  endtask : t_restore
  initial begin
    tick(8);
    aresetn <= 1'b1;
    t_boot;
    t_load;
    t_volt;
    t_curr;
    t_ena_heat;
    t_restore;
    tally_and_finish();
  end
endmodule : test_protection_latch_controller
